// [verilog/pattern_timer_pkg.sv]
// Register map, field positions and reset values of the timed pattern pulse block.
package pattern_timer_pkg;
   // ****************************************************************
   // Register indices; byte address is four times the index.
   // ****************************************************************
   localparam logic [23:0] IDX_PORT2_DIRECTION = 24'hFFFE21;
   localparam logic [23:0] IDX_TRANSFER_TRIGGER_ENABLE_C = 24'hFFFF2A;
   localparam logic [23:0] IDX_PATTERN_TRIGGER_SELECT = 24'hFFFF46;
   localparam logic [23:0] IDX_PATTERN_OUTPUT_MODE = 24'hFFFF47;
   localparam logic [23:0] IDX_NEXT_DATA_ENABLE_LOW = 24'hFFFF49;
   localparam logic [23:0] IDX_PATTERN_OUTPUT_DATA_LOW = 24'hFFFF4B;
   localparam logic [23:0] IDX_NEXT_PATTERN_LOW = 24'hFFFF4F;
   localparam logic [23:0] IDX_TIMER0_INTERRUPT_ENABLE = 24'hFFFFD4;
   localparam logic [23:0] IDX_TIMER0_STATUS = 24'hFFFFD5;
   localparam logic [23:0] IDX_TIMER0_COMPARE_A = 24'hFFFFD8;
   localparam logic [23:0] IDX_TIMER0_COMPARE_B = 24'hFFFFDA;
   localparam logic [23:0] IDX_PERIPHERAL_STOP_CONTROL = 24'hFFFF60;
   localparam logic [23:0] IDX_TIMER_START = 24'hFFFF61;
   localparam logic [23:0] IDX_TIMER0_CONTROL = 24'hFFFF62;
   localparam logic [23:0] IDX_CH0_COUNTER = 24'hFFFF63;

   // ****************************************************************
   // Field positions and codes.
   // ****************************************************************
   localparam int TRANSFER_ENGINE_STOP = 12;
   localparam int TIMER_UNIT_STOP = 11;
   localparam int PATTERN_GEN_STOP = 10;
   localparam int COMPARE_A_TRANSFER_ENABLE = 13;
   localparam int GROUP0_POLARITY = 4;
   localparam int GROUP0_OVERLAP_MODE = 0;
   localparam int CH0_COUNT_RUN = 0;
   localparam int COMPARE_A_IRQ_ENABLE = 0;
   localparam int COMPARE_A_FLAG = 0;
   localparam int COMPARE_B_FLAG = 1;
   localparam int CLEAR_SEL_LSB = 5;
   localparam int EDGE_SEL_LSB = 3;
   localparam int PRESCALE_SEL_LSB = 0;
   localparam logic [1:0] GROUP0_TRIGGER_CH0 = 2'h0;
   localparam logic [2:0] CLEAR_ON_A = 3'h1;
   localparam logic [2:0] CLEAR_ON_B = 3'h2;
   localparam logic [2:0] PRESCALE_DIV1 = 3'h0;
   localparam logic [2:0] PRESCALE_DIV4 = 3'h1;
   localparam logic [2:0] PRESCALE_DIV16 = 3'h2;
   localparam logic [2:0] PRESCALE_DIV64 = 3'h3;
   localparam logic [5:0] MASK_DIV1 = 6'h00;
   localparam logic [5:0] MASK_DIV4 = 6'h03;
   localparam logic [5:0] MASK_DIV16 = 6'h0F;
   localparam logic [5:0] MASK_DIV64 = 6'h3F;

   // ****************************************************************
   // Values after reset.
   // ****************************************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_HALF = 16'h0000;
   localparam logic [15:0] RST_COMPARE = 16'hFFFF;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : pattern_timer_pkg

// [verilog/pattern_pulse_timer.sv]
// Timer channel with compare-driven four-bit pattern pulse output and Wishbone registers.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - Stop bits at 1 halt engine, timer, pattern.
// - Direction bits at 1 drive pattern pins.
// - Trigger enable gates compare-A transfer request.
// - Trigger select 00 uses channel 0 matches.
// - Polarity 0 inverts, 1 drives direct.
// - Overlap bit 1 selects non-overlap operation.
// - Trigger copies next data where enabled.
// - Enabled output bits ignore software writes.
// - Run bit 0 stops, 1 counts.
// - Clear field 010 clears on B match.
// - Edge field 00 counts internal clock edges.
// - Prescale field 010 divides clock by 16.
// - Compare-A enable gates the interrupt request.
// - Status bits flag B and A matches.
// - Sixteen-bit compare A delay, B period.
// - Non-overlap: falls at B, rises at A.
module pattern_pulse_timer
   import pattern_timer_pkg::*;
#(
   parameter int COUNTER_WIDTH = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [31:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic [3:0] o_pattern_out,
   output logic [3:0] o_pattern_oe,
   output logic o_ch0_compare_a_irq,
   output logic o_transfer_req,
   output logic o_transfer_engine_stop
);

   // ****************************************************************
   // Parameter check.
   // ****************************************************************
   if (COUNTER_WIDTH != 16) begin : g_width_check
      $error("Counter width must be 16.");
   end

   // ****************************************************************
   // Registers.
   // ****************************************************************
   logic [7:0] port2_direction_q;
   logic [15:0] transfer_trigger_enable_c_q;
   logic [7:0] pattern_trigger_select_q;
   logic [7:0] pattern_output_mode_q;
   logic [7:0] next_data_enable_low_q;
   logic [7:0] pattern_output_data_low_q;
   logic [7:0] pattern_output_data_low_d;
   logic [7:0] next_pattern_low_q;
   logic [7:0] timer0_interrupt_enable_q;
   logic [1:0] flags_q;
   logic [1:0] flags_d;
   logic [1:0] armed_q;
   logic [15:0] timer0_compare_a_q;
   logic [15:0] timer0_compare_b_q;
   logic [15:0] peripheral_stop_control_q;
   logic [7:0] timer_start_q;
   logic [7:0] timer0_control_q;
   logic [15:0] ch0_counter_q;
   logic [15:0] ch0_counter_d;
   logic [5:0] presc_q;
   logic [7:0] held_rise_q;
   logic [31:0] rd_data;

   // ****************************************************************
   // Bus decode.
   // ****************************************************************
   wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire in_map = (i_wb_adr[31:26] == 6'h00);
   wire [23:0] idx = i_wb_adr[25:2];
   wire wr = req & i_wb_we & in_map;
   wire rd = req & ~i_wb_we & in_map;
   wire [15:0] wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
   wire [15:0] wdat = i_wb_dat[15:0];
   wire sel_dir = (idx == IDX_PORT2_DIRECTION);
   wire sel_tte = (idx == IDX_TRANSFER_TRIGGER_ENABLE_C);
   wire sel_pts = (idx == IDX_PATTERN_TRIGGER_SELECT);
   wire sel_pom = (idx == IDX_PATTERN_OUTPUT_MODE);
   wire sel_nde = (idx == IDX_NEXT_DATA_ENABLE_LOW);
   wire sel_pod = (idx == IDX_PATTERN_OUTPUT_DATA_LOW);
   wire sel_ndr = (idx == IDX_NEXT_PATTERN_LOW);
   wire sel_ien = (idx == IDX_TIMER0_INTERRUPT_ENABLE);
   wire sel_sts = (idx == IDX_TIMER0_STATUS);
   wire sel_cma = (idx == IDX_TIMER0_COMPARE_A);
   wire sel_cmb = (idx == IDX_TIMER0_COMPARE_B);
   wire sel_psc = (idx == IDX_PERIPHERAL_STOP_CONTROL);
   wire sel_tst = (idx == IDX_TIMER_START);
   wire sel_tcr = (idx == IDX_TIMER0_CONTROL);
   wire sel_cnt = (idx == IDX_CH0_COUNTER);
   wire we_dir = wr & sel_dir;
   wire we_tte = wr & sel_tte;
   wire we_pts = wr & sel_pts & i_wb_sel[0];
   wire we_pom = wr & sel_pom & i_wb_sel[0];
   wire we_nde = wr & sel_nde & i_wb_sel[0];
   wire we_ndr = wr & sel_ndr & i_wb_sel[0];
   wire we_ien = wr & sel_ien & i_wb_sel[0];
   wire we_cma = wr & sel_cma;
   wire we_cmb = wr & sel_cmb;
   wire we_psc = wr & sel_psc;
   wire we_tst = wr & sel_tst & i_wb_sel[0];
   wire we_tcr = wr & sel_tcr & i_wb_sel[0];

   assign rd_data =
      sel_dir ? {24'h000000, port2_direction_q} :
      sel_tte ? {16'h0000, transfer_trigger_enable_c_q} :
      sel_pts ? {24'h000000, pattern_trigger_select_q} :
      sel_pom ? {24'h000000, pattern_output_mode_q} :
      sel_nde ? {24'h000000, next_data_enable_low_q} :
      sel_pod ? {24'h000000, pattern_output_data_low_q} :
      sel_ndr ? {24'h000000, next_pattern_low_q} :
      sel_ien ? {24'h000000, timer0_interrupt_enable_q} :
      sel_sts ? {30'h00000000, flags_q} :
      sel_cma ? {16'h0000, timer0_compare_a_q} :
      sel_cmb ? {16'h0000, timer0_compare_b_q} :
      sel_psc ? {16'h0000, peripheral_stop_control_q} :
      sel_tst ? {24'h000000, timer_start_q} :
      sel_tcr ? {24'h000000, timer0_control_q} :
      sel_cnt ? {16'h0000, ch0_counter_q} : RST_WORD;

   // ****************************************************************
   // Timer channel 0.
   // ****************************************************************
   wire timer_stop = peripheral_stop_control_q[TIMER_UNIT_STOP];
   wire run = timer_start_q[CH0_COUNT_RUN] & ~timer_stop;
   wire [2:0] presc_sel = timer0_control_q[PRESCALE_SEL_LSB +: 3];
   wire [2:0] clear_sel = timer0_control_q[CLEAR_SEL_LSB +: 3];
   wire [5:0] presc_mask =
      (presc_sel == PRESCALE_DIV4) ? MASK_DIV4 :
      (presc_sel == PRESCALE_DIV16) ? MASK_DIV16 :
      (presc_sel == PRESCALE_DIV64) ? MASK_DIV64 : MASK_DIV1;
   // One tick per divided internal clock period, whatever edge field.
   wire tick = run & ((presc_q & presc_mask) == presc_mask);
   wire match_a = tick & (ch0_counter_q == timer0_compare_a_q);
   wire match_b = tick & (ch0_counter_q == timer0_compare_b_q);
   wire clr_cnt = (match_b & (clear_sel == CLEAR_ON_B)) |
      (match_a & (clear_sel == CLEAR_ON_A));

   always_comb begin
      ch0_counter_d = ch0_counter_q;
      if (wr & sel_cnt) begin
         ch0_counter_d = (ch0_counter_q & ~wmask) | (wdat & wmask);
      end else if (clr_cnt) begin
         ch0_counter_d = RST_HALF;
      end else if (tick) begin
         ch0_counter_d = ch0_counter_q + 16'h0001;
      end
   end

   // ****************************************************************
   // Status flags: a set in the clearing cycle wins.
   // ****************************************************************
   wire [1:0] flag_set = {match_b, match_a};
   wire [1:0] flag_clr = (wr & sel_sts & i_wb_sel[0]) ? (armed_q & ~wdat[1:0]) : 2'h0;
   assign flags_d = flag_set | (flags_q & ~flag_clr);

   // ****************************************************************
   // Pattern output group 0.
   // ****************************************************************
   wire pat_on = ~peripheral_stop_control_q[PATTERN_GEN_STOP] &
      (pattern_trigger_select_q[1:0] == GROUP0_TRIGGER_CH0);
   wire non_ovl = pattern_output_mode_q[GROUP0_OVERLAP_MODE];
   wire trig_b = pat_on & match_b;
   wire trig_a = pat_on & match_a & non_ovl;
   wire [7:0] ned = next_data_enable_low_q;
   wire [7:0] cpu_pod = (wr & sel_pod & i_wb_sel[0]) ?
      ((pattern_output_data_low_q & ned) | (wdat[7:0] & ~ned)) :
      pattern_output_data_low_q;

   always_comb begin
      pattern_output_data_low_d = cpu_pod;
      if (trig_b & ~non_ovl) begin
         pattern_output_data_low_d = (cpu_pod & ~ned) | (next_pattern_low_q & ned);
      end else if (trig_b) begin
         pattern_output_data_low_d = cpu_pod & ~(ned & ~next_pattern_low_q);
      end else if (trig_a) begin
         pattern_output_data_low_d = cpu_pod | held_rise_q;
      end
   end

   wire pol = pattern_output_mode_q[GROUP0_POLARITY];
   wire [3:0] pins = pol ? pattern_output_data_low_q[3:0] :
      ~pattern_output_data_low_q[3:0];

   // ****************************************************************
   // Register writes.
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         port2_direction_q <= RST_BYTE;
      end else if (we_dir) begin
         port2_direction_q <= (port2_direction_q & ~wmask[7:0]) | (wdat[7:0] & wmask[7:0]);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         transfer_trigger_enable_c_q <= RST_HALF;
      end else if (we_tte) begin
         transfer_trigger_enable_c_q <= (transfer_trigger_enable_c_q & ~wmask) | (wdat & wmask);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pattern_trigger_select_q <= RST_BYTE;
      end else if (we_pts) begin
         pattern_trigger_select_q <= wdat[7:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pattern_output_mode_q <= RST_BYTE;
      end else if (we_pom) begin
         pattern_output_mode_q <= wdat[7:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         next_data_enable_low_q <= RST_BYTE;
      end else if (we_nde) begin
         next_data_enable_low_q <= wdat[7:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         next_pattern_low_q <= RST_BYTE;
      end else if (we_ndr) begin
         next_pattern_low_q <= wdat[7:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         timer0_interrupt_enable_q <= RST_BYTE;
      end else if (we_ien) begin
         timer0_interrupt_enable_q <= wdat[7:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         timer0_compare_a_q <= RST_COMPARE;
      end else if (we_cma) begin
         timer0_compare_a_q <= (timer0_compare_a_q & ~wmask) | (wdat & wmask);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         timer0_compare_b_q <= RST_COMPARE;
      end else if (we_cmb) begin
         timer0_compare_b_q <= (timer0_compare_b_q & ~wmask) | (wdat & wmask);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         peripheral_stop_control_q <= RST_HALF;
      end else if (we_psc) begin
         peripheral_stop_control_q <= (peripheral_stop_control_q & ~wmask) | (wdat & wmask);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         timer_start_q <= RST_BYTE;
      end else if (we_tst) begin
         timer_start_q <= wdat[7:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         timer0_control_q <= RST_BYTE;
      end else if (we_tcr) begin
         timer0_control_q <= wdat[7:0];
      end
   end

   // ****************************************************************
   // Timer, flag and pattern state.
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ch0_counter_q <= RST_HALF;
         presc_q <= 6'h00;
      end else begin
         ch0_counter_q <= ch0_counter_d;
         presc_q <= run ? presc_q + 6'h01 : 6'h00;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         flags_q <= 2'h0;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         armed_q <= 2'h0;
      end else if (rd & sel_sts) begin
         armed_q <= flags_q;
      end else if (wr & sel_sts & i_wb_sel[0]) begin
         armed_q <= 2'h0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pattern_output_data_low_q <= RST_BYTE;
      end else begin
         pattern_output_data_low_q <= pattern_output_data_low_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         held_rise_q <= RST_BYTE;
      end else if (trig_b & non_ovl) begin
         held_rise_q <= ned & next_pattern_low_q;
      end else if (trig_a) begin
         held_rise_q <= RST_BYTE;
      end
   end

   // ****************************************************************
   // Outputs and bus answer.
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= RST_WORD;
         o_pattern_out <= 4'h0;
         o_pattern_oe <= 4'h0;
         o_ch0_compare_a_irq <= 1'b0;
         o_transfer_req <= 1'b0;
         o_transfer_engine_stop <= 1'b0;
      end else begin
         o_wb_ack <= req;
         o_wb_dat <= (req & ~i_wb_we & in_map) ? rd_data : RST_WORD;
         o_pattern_out <= pins;
         o_pattern_oe <= port2_direction_q[3:0];
         o_ch0_compare_a_irq <= flags_d[COMPARE_A_FLAG] &
            timer0_interrupt_enable_q[COMPARE_A_IRQ_ENABLE];
         o_transfer_req <= match_a &
            transfer_trigger_enable_c_q[COMPARE_A_TRANSFER_ENABLE] &
            ~peripheral_stop_control_q[TRANSFER_ENGINE_STOP];
         o_transfer_engine_stop <= peripheral_stop_control_q[TRANSFER_ENGINE_STOP];
      end
   end

endmodule : pattern_pulse_timer

// [bench/pattern_pulse_timer_props.sv]
// Port-level assertions for the timed pattern pulse timer.
`timescale 1ns/1ps
module pattern_pulse_timer_props
   import pattern_timer_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [31:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic [3:0] o_pattern_out,
   input wire logic [3:0] o_pattern_oe,
   input wire logic o_ch0_compare_a_irq,
   input wire logic o_transfer_req,
   input wire logic o_transfer_engine_stop
);
   // ****************************************************************
   // Bus decode and shadow copies of the enable bits.
   // ****************************************************************
   logic trig_en_q;
   logic irq_en_q;
   wire logic take = i_wb_cyc & i_wb_stb & ~o_wb_ack & (i_wb_adr[31:26] == 6'h00);
   wire logic wr = take & i_wb_we;
   wire logic rd = take & ~i_wb_we;
   wire logic [23:0] idx = i_wb_adr[25:2];
   wire logic wr_tier = wr & i_wb_sel[0] & (idx == IDX_TIMER0_INTERRUPT_ENABLE);
   wire logic wr_trig = wr & i_wb_sel[1] & (idx == IDX_TRANSFER_TRIGGER_ENABLE_C);
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         trig_en_q <= 1'b0;
         irq_en_q <= 1'b0;
      end else begin
         if (wr_trig) trig_en_q <= i_wb_dat[13];
         if (wr_tier) irq_en_q <= i_wb_dat[0];
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   AST_OE_FOLLOWS: assert property (wr && i_wb_sel[0] && idx == IDX_PORT2_DIRECTION
      |=> ##1 o_pattern_oe == $past(i_wb_dat[3:0], 2)) else $error("pin enable wrong");
   AST_ENGINE_STOP: assert property (wr && i_wb_sel[1] && idx == IDX_PERIPHERAL_STOP_CONTROL
      |=> ##1 o_transfer_engine_stop == $past(i_wb_dat[12], 2)) else $error("stop wrong");
   AST_STOP_NO_REQ: assert property (o_transfer_engine_stop[*3] |-> !o_transfer_req)
      else $error("request while stopped");
   AST_TRIG_GATE: assert property (!trig_en_q[*3] |-> !o_transfer_req)
      else $error("request while disabled");
   AST_IRQ_FALL: assert property ($fell(o_ch0_compare_a_irq) |->
      $past(wr && idx == IDX_TIMER0_STATUS) || $past(wr_tier, 2)) else $error("irq fell");
   AST_IRQ_MASK: assert property (wr_tier && !i_wb_dat[0] |-> ##2 !o_ch0_compare_a_irq)
      else $error("irq not masked");
   AST_IRQ_NEEDS_EN: assert property (!irq_en_q[*2] |-> !o_ch0_compare_a_irq)
      else $error("irq without enable");
   AST_STATUS_BITS: assert property (rd && idx == IDX_TIMER0_STATUS
      |=> o_wb_dat[31:2] == 30'h0) else $error("status upper bits");
   AST_CMP_WIDTH: assert property (rd && (idx == IDX_TIMER0_COMPARE_A ||
      idx == IDX_TIMER0_COMPARE_B) |=> o_wb_dat[31:16] == 16'h0) else $error("compare width");
endmodule : pattern_pulse_timer_props

bind pattern_pulse_timer pattern_pulse_timer_props u_props (.i_clk_sys, .i_sys_rst, .i_wb_cyc,
   .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_pattern_out,
   .o_pattern_oe, .o_ch0_compare_a_irq, .o_transfer_req, .o_transfer_engine_stop);

// [bench/motor_driver_model.sv]
// Motor driver inputs as seen through the four pattern pins.
`timescale 1ns/1ps
module motor_driver_model (
   input wire logic [3:0] i_pattern_out,
   input wire logic [3:0] i_pattern_oe,
   output logic [3:0] o_phase_level
);
   // ****************************************************************
   // Undriven pins are pulled low at the driver inputs.
   // ****************************************************************
   assign o_phase_level = i_pattern_oe & i_pattern_out;
endmodule : motor_driver_model

// [bench/tb_top.sv]
// Self-checking bench for the timed pattern pulse timer.
`timescale 1ns/1ps
module tb_top;
   import pattern_timer_pkg::*;
   logic clk, rst, cyc, stb, we;
   logic [3:0] sel;
   logic [31:0] adr, wdat, rd;
   wire logic [31:0] rdat;
   wire logic ack, irq, req, estop;
   wire logic [3:0] pout, poe, phase;
   int miscompares, cmp_count, cycles, t0, t1, k;
   pattern_pulse_timer uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .o_pattern_out(pout), .o_pattern_oe(poe), .o_ch0_compare_a_irq(irq),
      .o_transfer_req(req), .o_transfer_engine_stop(estop));
   motor_driver_model drv (.i_pattern_out(pout), .i_pattern_oe(poe), .o_phase_level(phase));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cycles <= cycles + 1;
   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   task timed_out;
      miscompares++;
      end_of_test();
   endtask : timed_out
   task bus(input logic w, input logic [23:0] i, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {6'h00, i, 2'h0};
      sel <= 4'h3;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) timed_out();
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task rdc(input logic [23:0] i, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, i, 32'h0);
      check(rd & m, e);
   endtask : rdc
   task wait_pins(input logic [3:0] old, output int t);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (phase === old && n < 3000);
      if (phase === old) timed_out();
      t = cycles;
   endtask : wait_pins
   task wait_req;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (req !== 1'b1 && n < 500);
      if (req !== 1'b1) timed_out();
   endtask : wait_req
   task quiet(input int n, output int c);
      logic [3:0] p;
      c = 0;
      repeat (2) @(posedge clk);
      p = phase;
      repeat (n) begin
         @(posedge clk);
         if (phase !== p || req === 1'b1) c++;
      end
   endtask : quiet
   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task t_reset;
      rdc(IDX_TIMER0_COMPARE_A, 32'hFFFFFFFF, 32'h0000FFFF);
      rdc(IDX_TIMER0_STATUS, 32'hFFFFFFFF, 32'h0);
      rdc(24'h000010, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, IDX_PORT2_DIRECTION, 32'h0F);
      repeat (3) @(posedge clk);
      check(phase, 4'hF);
   endtask : t_reset
   task t_normal;
      bus(1'b1, IDX_PATTERN_TRIGGER_SELECT, 32'h0);
      bus(1'b1, IDX_PATTERN_OUTPUT_MODE, 32'h10);
      bus(1'b1, IDX_PATTERN_OUTPUT_DATA_LOW, 32'h05);
      bus(1'b1, IDX_NEXT_DATA_ENABLE_LOW, 32'h0F);
      bus(1'b1, IDX_PATTERN_OUTPUT_DATA_LOW, 32'h0A);
      rdc(IDX_PATTERN_OUTPUT_DATA_LOW, 32'hFF, 32'h05);
      check(phase, 4'h5);
      bus(1'b1, IDX_NEXT_PATTERN_LOW, 32'h0C);
      bus(1'b1, IDX_TIMER0_COMPARE_B, 32'h3);
      bus(1'b1, IDX_TIMER0_CONTROL, 32'h42);
      bus(1'b1, IDX_TIMER_START, 32'h1);
      wait_pins(4'h5, t0);
      check(phase, 4'hC);
      bus(1'b1, IDX_NEXT_PATTERN_LOW, 32'h03);
      wait_pins(4'hC, t1);
      check(phase, 4'h3);
      check(t1 - t0, 64);
      rdc(IDX_TIMER0_STATUS, 32'h2, 32'h2);
      bus(1'b1, IDX_TIMER_START, 32'h0);
      bus(1'b1, IDX_NEXT_PATTERN_LOW, 32'h0C);
      quiet(200, k);
      check(k, 0);
      rdc(IDX_TIMER0_STATUS, 32'h3, 32'h2);
      bus(1'b1, IDX_TIMER0_STATUS, 32'h0);
      rdc(IDX_TIMER0_STATUS, 32'hFF, 32'h0);
      bus(1'b1, IDX_PATTERN_OUTPUT_MODE, 32'h00);
      repeat (3) @(posedge clk);
      check(phase, 4'hC);
   endtask : t_normal
   task t_nonoverlap;
      bus(1'b1, IDX_CH0_COUNTER, 32'h0);
      bus(1'b1, IDX_TIMER0_COMPARE_A, 32'h1);
      bus(1'b1, IDX_PATTERN_OUTPUT_MODE, 32'h11);
      bus(1'b1, IDX_NEXT_DATA_ENABLE_LOW, 32'h00);
      bus(1'b1, IDX_PATTERN_OUTPUT_DATA_LOW, 32'h06);
      bus(1'b1, IDX_NEXT_DATA_ENABLE_LOW, 32'h0F);
      bus(1'b1, IDX_TIMER0_INTERRUPT_ENABLE, 32'h1);
      bus(1'b1, IDX_TRANSFER_TRIGGER_ENABLE_C, 32'h2000);
      bus(1'b1, IDX_TIMER_START, 32'h1);
      wait_req();
      bus(1'b1, IDX_NEXT_PATTERN_LOW, 32'h03);
      bus(1'b1, IDX_TIMER0_COMPARE_B, 32'h3);
      check(irq, 1'b1);
      wait_pins(4'h6, t0);
      check(phase, 4'h2);
      wait_pins(4'h2, t1);
      check(phase, 4'h3);
      check(t1 - t0, 32);
      rdc(IDX_TIMER0_STATUS, 32'h3, 32'h3);
      bus(1'b1, IDX_TIMER0_INTERRUPT_ENABLE, 32'h0);
      repeat (3) @(posedge clk);
      check(irq, 1'b0);
   endtask : t_nonoverlap
   task t_stops;
      bus(1'b1, IDX_PERIPHERAL_STOP_CONTROL, 32'h1000);
      quiet(200, k);
      check(k, 0);
      check(estop, 1'b1);
      bus(1'b1, IDX_TRANSFER_TRIGGER_ENABLE_C, 32'h0);
      bus(1'b1, IDX_PERIPHERAL_STOP_CONTROL, 32'h0);
      quiet(200, k);
      check(k, 0);
      bus(1'b1, IDX_PATTERN_TRIGGER_SELECT, 32'h1);
      bus(1'b1, IDX_NEXT_PATTERN_LOW, 32'h0C);
      quiet(200, k);
      check(k, 0);
      bus(1'b1, IDX_PERIPHERAL_STOP_CONTROL, 32'h0400);
      bus(1'b1, IDX_PATTERN_TRIGGER_SELECT, 32'h0);
      quiet(200, k);
      check(k, 0);
      bus(1'b1, IDX_PERIPHERAL_STOP_CONTROL, 32'h0800);
      bus(1'b1, IDX_TRANSFER_TRIGGER_ENABLE_C, 32'h2000);
      quiet(200, k);
      check(k, 0);
      bus(1'b1, IDX_PERIPHERAL_STOP_CONTROL, 32'h0);
      wait_pins(4'h3, t0);
      check(phase, 4'h0);
   endtask : t_stops
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'h0;
      adr = 32'h0;
      wdat = 32'h0;
      cycles = 0;
      miscompares = 0;
      cmp_count = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_normal();
      t_nonoverlap();
      t_stops();
      end_of_test();
   end
endmodule : tb_top
